/* gpio_port_with_masked_data_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
   n_fail++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module gpio_port_with_masked_data_tb;
   import gpm_pkg::*;
   logic ref_clk;
   logic rstn;
   gpm_apb_req_t apb_req;
   logic [GPM_DW-1:0] prdata;
   logic pready;
   logic pslverr;
   logic [GPM_PINS-1:0] pad_in;
   logic [GPM_PINS-1:0] ext_lvl;
   logic [GPM_PINS-1:0] dma_trigger_enable;
   gpm_pad_drv_t pad_drv;
   logic dma_trig;
   logic irq;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [7:0] n_trig = 8'h00;

   gpm_port gpm_port_i (.ref_clk(ref_clk), .rstn(rstn), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
      .pad_drv(pad_drv), .dma_trigger_enable(dma_trigger_enable),
      .dma_trig(dma_trig), .irq(irq));
   gpm_pad_model gpm_pad_model_i (.pad_drv(pad_drv), .ext_lvl(ext_lvl),
      .pad_lvl(pad_in));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // the pulse is counted mid-cycle, away from the edge that launches it
   always @(negedge ref_clk) begin
      cyc++;
      if (dma_trig === 1'b1) n_trig <= n_trig + 8'h01;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // an idle cycle follows each access, so a write is never repeated
   task automatic apb(input logic we, input logic [GPM_AW-1:0] a,
                      input logic [GPM_DW-1:0] d, output logic [GPM_DW-1:0] q);
      @(negedge ref_clk);
      apb_req = '{psel: 1'b1, penable: 1'b0, pwrite: we, paddr: a, pwdata: d};
      @(negedge ref_clk);
      apb_req.penable = 1'b1;
      @(posedge ref_clk);
      q = prdata;
      @(negedge ref_clk);
      apb_req.psel = 1'b0;
      apb_req.penable = 1'b0;
   endtask : apb

   task automatic wr(input logic [GPM_AW-1:0] a, input logic [GPM_DW-1:0] d);
      logic [GPM_DW-1:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [GPM_AW-1:0] a,
                         input logic [GPM_DW-1:0] e);
      logic [GPM_DW-1:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      `CHK(q, e)
   endtask : rd_chk

   task automatic pads(input logic [GPM_PINS-1:0] v);
      @(negedge ref_clk);
      ext_lvl = v;
      repeat (5) @(negedge ref_clk);
   endtask : pads

   initial begin
      apb_req = '0;
      ext_lvl = 8'hA0;
      dma_trigger_enable = 8'h10;
      rstn = 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      `CHK(pad_drv, 16'h0000)
      // the port clock counts as enabled at reset release
      repeat (GPM_CLK_EN_WAIT) @(negedge ref_clk);
      for (int a = 'h400; a <= 'h418; a += 4) begin
         rd_chk(12'(a), GPM_RST_WORD);
      end
      rd_chk(12'h03FC, 32'h0000_00A0);
      wr(GPM_OFS_DIR, 32'h0000_000F);
      wr(12'h0098, 32'h0000_00EB);
      @(negedge ref_clk);
      `CHK(pad_drv.pad_oe, 8'h0F)
      `CHK(pad_drv.pad_out, 8'h02)
      rd_chk(12'h03FC, 32'h0000_00A2);
      rd_chk(12'h00C4, 32'h0000_0020);
      wr(12'h03FC, 32'hFFFF_FFFF);
      rd_chk(12'h03FC, 32'h0000_00AF);
      wr(12'h0004, 32'h0000_0000);
      rd_chk(12'h03FC, 32'h0000_00AE);
      wr(12'h0420, 32'h0000_00FF);
      rd_chk(12'h0420, 32'h0000_0000);
      `CHK(pslverr, 1'b0)
      `CHK(pready, 1'b1)
      // mask first, then configure, clear, and unmask
      wr(GPM_OFS_MASK, 32'h0000_0000);
      wr(GPM_OFS_SENSE, 32'h0000_0040);
      wr(GPM_OFS_BOTH, 32'h0000_0020);
      wr(GPM_OFS_POL, 32'h0000_0050);
      wr(GPM_OFS_CLR, 32'h0000_00FF);
      wr(GPM_OFS_MASK, 32'h0000_00F0);
      rd_chk(GPM_OFS_RAW, 32'h0000_0000);
      rd_chk(GPM_OFS_MASK, 32'h0000_00F0);
      pads(8'hB0);
      repeat (10) @(negedge ref_clk);
      rd_chk(GPM_OFS_RAW, 32'h0000_0010);
      rd_chk(GPM_OFS_MIS, 32'h0000_0010);
      `CHK(irq, 1'b1)
      wr(GPM_OFS_CLR, 32'h0000_0010);
      rd_chk(GPM_OFS_RAW, 32'h0000_0000);
      pads(8'h10);
      rd_chk(GPM_OFS_RAW, 32'h0000_00A0);
      rd_chk(GPM_OFS_MIS, 32'h0000_00A0);
      wr(GPM_OFS_MASK, 32'h0000_0010);
      rd_chk(GPM_OFS_MIS, 32'h0000_0000);
      `CHK(irq, 1'b0)
      wr(GPM_OFS_CLR, 32'h0000_00A0);
      rd_chk(GPM_OFS_CLR, 32'h0000_0000);
      wr(GPM_OFS_MASK, 32'h0000_0040);
      pads(8'h50);
      rd_chk(GPM_OFS_RAW, 32'h0000_0040);
      `CHK(irq, 1'b1)
      pads(8'h10);
      rd_chk(GPM_OFS_RAW, 32'h0000_0000);
      `CHK(irq, 1'b0)
      `CHK(n_trig, 8'h01)
      rd_chk(GPM_OFS_DIR, 32'h0000_000F);
      tally_and_finish();
   end
endmodule : gpio_port_with_masked_data_tb
`default_nettype wire

/* gpm_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpm_pad_model
   import gpm_pkg::*;
(
   input wire gpm_pad_drv_t pad_drv, // port drive value and enables
   input wire logic [GPM_PINS-1:0] ext_lvl, // far-side source on inputs
   output logic [GPM_PINS-1:0] pad_lvl // resolved pad level
);
   // an enabled pin carries the port's value; others follow the far side
   // every pad is taken as muxed to the gpio function
   always_comb begin
      for (int i = 0; i < GPM_PINS; i++) begin
         pad_lvl[i] = pad_drv.pad_oe[i] ? pad_drv.pad_out[i] : ext_lvl[i];
      end
   end
endmodule : gpm_pad_model
`default_nettype wire

/* gpm_pkg.sv */
package gpm_pkg;
   localparam int GPM_PINS = 8;
   localparam int GPM_AW = 12;
   localparam int GPM_DW = 32;
   // pin-data aliases fill offsets below this one
   localparam logic [GPM_AW-1:0] GPM_DATA_TOP = 12'h0400;
   localparam int GPM_MASK_LSB = 2;
   localparam int GPM_MASK_MSB = 9;
   localparam logic [GPM_AW-1:0] GPM_OFS_DIR = 12'h0400;
   localparam logic [GPM_AW-1:0] GPM_OFS_SENSE = 12'h0404;
   localparam logic [GPM_AW-1:0] GPM_OFS_BOTH = 12'h0408;
   localparam logic [GPM_AW-1:0] GPM_OFS_POL = 12'h040c;
   localparam logic [GPM_AW-1:0] GPM_OFS_MASK = 12'h0410;
   localparam logic [GPM_AW-1:0] GPM_OFS_RAW = 12'h0414;
   localparam logic [GPM_AW-1:0] GPM_OFS_MIS = 12'h0418;
   localparam logic [GPM_AW-1:0] GPM_OFS_CLR = 12'h041c;
   localparam logic [GPM_PINS-1:0] GPM_RST_BYTE = 8'h00;
   localparam logic [GPM_DW-1:0] GPM_RST_WORD = 32'h0000_0000;
   // port base addresses, decoded by the system fabric
   localparam logic [31:0] GPM_BASE_P0 = 32'h4000_4000;
   localparam logic [31:0] GPM_BASE_STEP = 32'h0000_1000;
   // cycles the master waits after enabling the port clock
   localparam int GPM_CLK_EN_WAIT = 3;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [GPM_AW-1:0] paddr;
      logic [GPM_DW-1:0] pwdata;
   } gpm_apb_req_t;

   typedef struct packed {
      logic [GPM_PINS-1:0] pad_out;
      logic [GPM_PINS-1:0] pad_oe;
   } gpm_pad_drv_t;
endpackage : gpm_pkg

/* gpm_port.sv */
// Behaviour
// RULE1 - any pin event on a trigger-enabled pin pulses the DMA trigger
// RULE2 - direction bit 1 makes the pin an output, 0 an input
// RULE3 - sense 0 edge/1 level; both-edges 0 single/1 both; polarity selects
// RULE4 - interrupt mask 0 blocks a pin's interrupt, 1 passes it
// RULE5 - software masks, reprograms, clears raw status, then unmasks
// RULE6 - output pins drive pin data; input pins show the pad level
// RULE7 - registers sit at fixed APB offsets from the port base
// RULE8 - master enables port clock and waits 3 cycles before access
// RULE9 - pin data has 256 word aliases; address bits 9:2 mask data bits
// RULE10 - a write leaves data bits with clear mask bits unchanged
// RULE11 - a read returns zero for data bits with clear mask bits
// RULE12 - unmasked read bits give written value for outputs, pad for inputs
// RULE13 - a write changes only unmasked bits on output pins
// RULE14 - reset clears all pin-data bits
// RULE15 - pin-data bits 31 to 8 read as zero
// RULE16 - software selects the GPIO pad function before use
// RULE17 - edge raw status holds until a one is written to the clear bit
// RULE18 - level raw status follows the input and clears on its own
// RULE19 - masked status is raw status ANDed with mask
// RULE20 - one interrupt output is high while any masked status bit is set
// RULE21 - edges compare synchronised sample with the previous sample
`timescale 1ns/1ps
`default_nettype none
module gpm_port
   import gpm_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire gpm_apb_req_t apb_req, // apb request signals
   output logic [GPM_DW-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [GPM_PINS-1:0] pad_in, // pad levels
   output gpm_pad_drv_t pad_drv, // pad drive and enables
   input wire logic [GPM_PINS-1:0] dma_trigger_enable, // pins as dma source
   output logic dma_trig, // dma trigger, one cycle per edge event, held high while a level hit lasts
   output logic irq // port interrupt
);
   logic [GPM_PINS-1:0] data_r;
   logic [GPM_PINS-1:0] dir_r;
   logic [GPM_PINS-1:0] sense_r;
   logic [GPM_PINS-1:0] both_r;
   logic [GPM_PINS-1:0] pol_r;
   logic [GPM_PINS-1:0] mask_r;
   logic [GPM_PINS-1:0] raw_r;
   logic [GPM_PINS-1:0] raw_nxt;
   logic [GPM_PINS-1:0] sync1_r;
   logic [GPM_PINS-1:0] sync2_r;
   logic [GPM_PINS-1:0] prev_r;
   logic [GPM_DW-1:0] rdata_r;
   logic [GPM_DW-1:0] rdata_nxt;
   logic dma_r;
   logic [GPM_PINS-1:0] addr_mask;
   logic [GPM_PINS-1:0] pin_view;
   logic [GPM_PINS-1:0] edge_evt;
   logic [GPM_PINS-1:0] level_hit;
   logic [GPM_PINS-1:0] clr_bits;
   logic [GPM_PINS-1:0] wbyte;
   logic setup_ph;
   logic wr_en;
   logic data_sel;

   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign data_sel = apb_req.paddr < GPM_DATA_TOP; // [RULE9]
   assign addr_mask = apb_req.paddr[GPM_MASK_MSB:GPM_MASK_LSB]; // [RULE9]
   assign wbyte = apb_req.pwdata[GPM_PINS-1:0];
   // zero-wait slave; unmapped offsets read zero rather than erroring
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = rdata_r;

   // pads cross into ref_clk through two flops before any logic
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= GPM_RST_BYTE;
         sync2_r <= GPM_RST_BYTE;
         prev_r <= GPM_RST_BYTE;
      end else begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r; // [RULE21]
      end
   end

   // inputs show the synchronised pad, outputs the written value
   assign pin_view = (dir_r & data_r) | (~dir_r & sync2_r); // [RULE6] [RULE12]

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         data_r <= GPM_RST_BYTE; // [RULE14]
      end else if (wr_en && data_sel) begin
         // keep masked-off bits and input pins untouched
         data_r <= (data_r & ~(addr_mask & dir_r))
            | (wbyte & addr_mask & dir_r); // [RULE10] [RULE13]
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dir_r <= GPM_RST_BYTE;
         sense_r <= GPM_RST_BYTE;
         both_r <= GPM_RST_BYTE;
         pol_r <= GPM_RST_BYTE;
         mask_r <= GPM_RST_BYTE;
      end else if (wr_en) begin
         case (apb_req.paddr) // [RULE7]
            GPM_OFS_DIR: dir_r <= wbyte; // [RULE2]
            GPM_OFS_SENSE: sense_r <= wbyte; // [RULE3]
            GPM_OFS_BOTH: both_r <= wbyte; // [RULE3]
            GPM_OFS_POL: pol_r <= wbyte; // [RULE3]
            GPM_OFS_MASK: mask_r <= wbyte; // [RULE4]
            default: ;
         endcase
      end
   end

   // one assignment drives the whole struct, so the output has one driver
   assign pad_drv = '{pad_out: data_r, pad_oe: dir_r}; // [RULE6] [RULE2]

   // detection; raw bits may glitch while config changes, hence the
   // mask-reprogram-clear-unmask order expected of software
   assign edge_evt = ~sense_r & (sync2_r ^ prev_r)
      & (both_r | ~(pol_r ^ sync2_r)); // [RULE3] [RULE21]
   assign level_hit = sense_r & ~(pol_r ^ sync2_r); // [RULE3]
   assign clr_bits = (wr_en && apb_req.paddr == GPM_OFS_CLR)
      ? wbyte : GPM_RST_BYTE;

   always_comb begin
      // a new edge in the clear cycle wins over the clear
      raw_nxt = (raw_r & ~clr_bits & ~sense_r) | edge_evt; // [RULE17]
      raw_nxt = raw_nxt | level_hit; // [RULE18]
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         raw_r <= GPM_RST_BYTE;
      end else begin
         raw_r <= raw_nxt;
      end
   end

   assign irq = |(raw_r & mask_r); // [RULE4] [RULE19] [RULE20]

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dma_r <= 1'b0;
      end else begin
         dma_r <= |((edge_evt | level_hit) & dma_trigger_enable); // [RULE1]
      end
   end
   assign dma_trig = dma_r;

   always_comb begin
      rdata_nxt = GPM_RST_WORD;
      if (data_sel) begin
         rdata_nxt[GPM_PINS-1:0] = pin_view & addr_mask; // [RULE11] [RULE15]
      end else begin
         case (apb_req.paddr)
            GPM_OFS_DIR: rdata_nxt[GPM_PINS-1:0] = dir_r;
            GPM_OFS_SENSE: rdata_nxt[GPM_PINS-1:0] = sense_r;
            GPM_OFS_BOTH: rdata_nxt[GPM_PINS-1:0] = both_r;
            GPM_OFS_POL: rdata_nxt[GPM_PINS-1:0] = pol_r;
            GPM_OFS_MASK: rdata_nxt[GPM_PINS-1:0] = mask_r;
            GPM_OFS_RAW: rdata_nxt[GPM_PINS-1:0] = raw_r;
            GPM_OFS_MIS: rdata_nxt[GPM_PINS-1:0] = raw_r & mask_r; // [RULE19]
            default: rdata_nxt = GPM_RST_WORD;
         endcase
      end
   end

   // read data is captured in the setup phase, so it is stable in access
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= GPM_RST_WORD;
      end else if (setup_ph && !apb_req.pwrite) begin
         rdata_r <= rdata_nxt;
      end
   end

   sequence s_data_wr;
      wr_en && data_sel;
   endsequence

   sequence s_data_rd;
      setup_ph && !apb_req.pwrite && data_sel;
   endsequence

   property p_dir_write;
      @(posedge ref_clk) disable iff (!rstn)
         (wr_en && apb_req.paddr == GPM_OFS_DIR)
         |=> pad_drv.pad_oe == $past(wbyte);
   endproperty
   a_dir_write: assert property (p_dir_write) // [RULE2]
      else $error("direction write not reflected on pad enables");

   property p_data_keep;
      @(posedge ref_clk) disable iff (!rstn)
         s_data_wr |=> ((data_r ^ $past(data_r))
         & ~($past(addr_mask) & $past(dir_r))) == 8'h00;
   endproperty
   a_data_keep: assert property (p_data_keep) // [RULE10]
      else $error("masked or input data bit changed on write");

   property p_data_drive;
      @(posedge ref_clk) disable iff (!rstn)
         s_data_wr |=> ((pad_drv.pad_out ^ $past(wbyte))
         & $past(addr_mask) & $past(dir_r)) == 8'h00;
   endproperty
   a_data_drive: assert property (p_data_drive) // [RULE13]
      else $error("unmasked output bit not written to pad");

   property p_read_mask;
      @(posedge ref_clk) disable iff (!rstn)
         s_data_rd |=> (prdata[GPM_PINS-1:0] & ~$past(addr_mask)) == 8'h00
         && prdata[GPM_DW-1:GPM_PINS] == 24'h00_0000;
   endproperty
   a_read_mask: assert property (p_read_mask) // [RULE11]
      else $error("masked or reserved data bit read nonzero");

   property p_read_src;
      @(posedge ref_clk) disable iff (!rstn)
         s_data_rd |=> prdata[GPM_PINS-1:0] == ($past(addr_mask)
         & (($past(dir_r) & $past(data_r))
         | (~$past(dir_r) & $past(sync2_r))));
   endproperty
   a_read_src: assert property (p_read_src) // [RULE12]
      else $error("data read source wrong");

   property p_reset_data;
      @(posedge ref_clk) $rose(rstn) |-> data_r == 8'h00;
   endproperty
   a_reset_data: assert property (p_reset_data) // [RULE14]
      else $error("pin data not cleared by reset");

   property p_edge_hold;
      @(posedge ref_clk) disable iff (!rstn)
         (|(raw_r & ~sense_r & ~clr_bits))
         |=> |(raw_r & $past(raw_r & ~sense_r & ~clr_bits));
   endproperty
   a_edge_hold: assert property (p_edge_hold) // [RULE17]
      else $error("edge status lost without clear");

   property p_edge_clear;
      @(posedge ref_clk) disable iff (!rstn)
         (|(clr_bits & ~sense_r & ~edge_evt))
         |=> (raw_r & $past(clr_bits & ~sense_r & ~edge_evt)) == 8'h00;
   endproperty
   a_edge_clear: assert property (p_edge_clear) // [RULE17]
      else $error("edge status not cleared");

   property p_rise_set;
      @(posedge ref_clk) disable iff (!rstn)
         (|(~sense_r & ~both_r & pol_r & ~prev_r & sync2_r))
         |=> |(raw_r & $past(~sense_r & ~both_r & pol_r & sync2_r));
   endproperty
   a_rise_set: assert property (p_rise_set) // [RULE21]
      else $error("rising edge not captured");

   property p_level;
      @(posedge ref_clk) disable iff (!rstn)
         ##1 ((raw_r ^ $past(level_hit)) & $past(sense_r)) == 8'h00;
   endproperty
   a_level: assert property (p_level) // [RULE18]
      else $error("level status does not follow input");

   property p_irq;
      @(posedge ref_clk) disable iff (!rstn)
         irq == (rdata_nxt[GPM_PINS-1:0] != 8'h00)
         || apb_req.paddr != GPM_OFS_MIS;
   endproperty
   a_irq: assert property (p_irq) // [RULE20]
      else $error("interrupt disagrees with masked status");

   property p_dma;
      @(posedge ref_clk) disable iff (!rstn)
         (|(edge_evt & dma_trigger_enable)) |=> dma_trig;
   endproperty
   a_dma: assert property (p_dma) // [RULE1]
      else $error("pin event gave no dma trigger");

   property p_fall_set;
      @(posedge ref_clk) disable iff (!rstn)
         (|(~sense_r & ~both_r & ~pol_r & prev_r & ~sync2_r))
         |=> |(raw_r & $past(~sense_r & ~both_r & ~pol_r & ~sync2_r));
   endproperty
   a_fall_set: assert property (p_fall_set) // [RULE3]
      else $error("falling edge not captured");

   property p_both_set;
      @(posedge ref_clk) disable iff (!rstn)
         (|(~sense_r & both_r & (prev_r ^ sync2_r)))
         |=> |(raw_r & $past(~sense_r & both_r & (prev_r ^ sync2_r)));
   endproperty
   a_both_set: assert property (p_both_set) // [RULE3]
      else $error("edge on a both-edges pin not captured");

   property p_mis_read;
      @(posedge ref_clk) disable iff (!rstn)
         (setup_ph && !apb_req.pwrite && apb_req.paddr == GPM_OFS_MIS)
         |=> prdata[GPM_PINS-1:0] == ($past(raw_r) & $past(mask_r));
   endproperty
   a_mis_read: assert property (p_mis_read) // [RULE19]
      else $error("masked status read differs from raw and mask");
endmodule : gpm_port
`default_nettype wire
